// ===== rtl/memory_attribute_combiner.v
`timescale 1ns/1ps
`include "attr_combiner_consts.vh"
module memory_attribute_combiner #(
   parameter ADDR_W         = 40,
   parameter INSTR_ON_WRITE = 0
) (
   input  wire                clk_sys,
   input  wire                resetn,
   // Client request
   input  wire                req_valid,
   output wire                req_ready,
   input  wire [ADDR_W-1:0]   req_addr,
   input  wire                req_write,
   input  wire [2:0]          req_mem_type,
   input  wire [1:0]          req_share,
   input  wire                req_ra,
   input  wire                req_wa,
   input  wire                req_ns,
   input  wire                req_instr,
   input  wire                req_priv,
   // Context selection
   input  wire                global_bypass,
   input  wire                entry_bypass,
   input  wire [1:0]          bank_type,
   input  wire                s1_hyp_context_bit,
   input  wire                s2_hyp_context_bit,
   input  wire                stage1_support,
   // Transformation field groups
   input  wire [`XF_W-1:0]    global_control_reg,
   input  wire [`XF_W-1:0]    stream_to_context_entry,
   input  wire [1:0]          instr_fetch_cfg,
   input  wire [1:0]          privilege_cfg,
   input  wire [`XF_W-1:0]    s1_bank_control_reg,
   input  wire                s1_mmu_enable_bit,
   input  wire [`XF_W-1:0]    s2_bank_control_reg,
   input  wire                s2_mmu_enable_bit,
   input  wire [`XF_W-1:0]    bank_attribute_reg,
   // Descriptor results
   input  wire [ADDR_W-1:0]   xlat_addr,
   input  wire [2:0]          s1_desc_mem_type,
   input  wire [1:0]          s1_desc_share,
   input  wire                s1_desc_ra,
   input  wire                s1_desc_wa,
   input  wire                s1_desc_ns,
   input  wire [2:0]          s2_desc_mem_type,
   input  wire [1:0]          s2_desc_share,
   input  wire [1:0]          s2_desc_read_alloc_cfg,
   input  wire [1:0]          s2_desc_write_alloc_cfg,
   // Downstream
   output wire                out_valid,
   input  wire                out_ready,
   output reg  [ADDR_W-1:0]   out_addr,
   output reg                 out_write,
   output reg  [2:0]          out_mem_type,
   output reg  [1:0]          out_share,
   output reg                 out_ra,
   output reg                 out_wa,
   output reg                 out_ns,
   output reg                 out_instr,
   output reg                 out_priv,
   output reg                 out_hyp,
   output reg                 cfg_error
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function [2:0] stronger_mt;
      input [2:0] a;
      input [2:0] b;
      begin
         stronger_mt = (a < b) ? a : b;
      end
   endfunction

   function [1:0] stronger_sh;
      input [1:0] a;
      input [1:0] b;
      begin
         stronger_sh = (a < b) ? a : b;
      end
   endfunction

   function alloc_apply;
      input [1:0] cfg;
      input       prev;
      begin
         case (cfg)
            `ALLOC_FORCE: alloc_apply = 1'b1;
            `ALLOC_NONE:  alloc_apply = 1'b0;
            default:      alloc_apply = prev; // Reserved code keeps the hint
         endcase
      end
   endfunction

   function ip_apply;
      input [1:0] cfg;
      input       prev;
      begin
         case (cfg)
            `IP_SET: ip_apply = 1'b1;
            `IP_CLR: ip_apply = 1'b0;
            default: ip_apply = prev;
         endcase
      end
   endfunction

   // Field extractors for one transformation group
   function [1:0] field_ns;
      input [`XF_W-1:0] f;
      begin
         field_ns = f[`XF_NS_LSB+1:`XF_NS_LSB];
      end
   endfunction

   function [1:0] field_wa;
      input [`XF_W-1:0] f;
      begin
         field_wa = f[`XF_WA_LSB+1:`XF_WA_LSB];
      end
   endfunction

   function [1:0] field_ra;
      input [`XF_W-1:0] f;
      begin
         field_ra = f[`XF_RA_LSB+1:`XF_RA_LSB];
      end
   endfunction

   function field_mem_type_cfg;
      input [`XF_W-1:0] f;
      begin
         field_mem_type_cfg = f[`XF_MEM_TYPE_CFG];
      end
   endfunction

   function [2:0] field_mt;
      input [`XF_W-1:0] f;
      begin
         field_mt = f[`XF_MT_LSB+2:`XF_MT_LSB];
      end
   endfunction

   function [1:0] field_sh;
      input [`XF_W-1:0] f;
      begin
         field_sh = f[`XF_SH_LSB+1:`XF_SH_LSB];
      end
   endfunction

   // Packs {ns,ra,wa,mt,sh} as 8 bits; applies one transformation group
   function [7:0] xform;
      input [`XF_W-1:0] f;
      input [7:0]       a;
      input             use_ns;
      reg   [1:0]       ns_cfg;
      reg   [1:0]       sh_cfg;
      reg               ns_v;
      reg               ra_v;
      reg               wa_v;
      reg   [2:0]       mt_v;
      reg   [1:0]       sh_v;
      reg               xf_ok;
      begin
         ns_cfg = field_ns(f);
         sh_cfg = field_sh(f);
         ns_v   = a[7];
         ra_v   = a[6];
         wa_v   = a[5];
         mt_v   = a[4:2];
         sh_v   = a[1:0];
         // Strong incoming types skip transform unless forced; cheaper than a full remap
         xf_ok  = field_mem_type_cfg(f) || (mt_v > `MT_DEV);
         if (xf_ok) begin
            if (field_mem_type_cfg(f))
               mt_v = field_mt(f);
            ra_v = alloc_apply(field_ra(f), ra_v);
            wa_v = alloc_apply(field_wa(f), wa_v);
            if (sh_cfg != `SHAREABILITY_CFG_KEEP)
               sh_v = sh_cfg;
         end
         // Nonsecure override applies even when the encoding is left alone; secure override only when it is transformed
         if (use_ns && ns_cfg == `NS_NONSEC)
            ns_v = 1'b1;
         else if (use_ns && ns_cfg == `NS_SEC && xf_ok)
            ns_v = 1'b0;
         xform = {ns_v, ra_v, wa_v, mt_v, sh_v};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Combining
   wire [7:0] in_attr = {req_ns, req_ra, req_wa, req_mem_type, req_share};
   // Stage 1 descriptor result in the packed order
   wire [7:0] s1_desc_attr = {s1_desc_ns, s1_desc_ra, s1_desc_wa, s1_desc_mem_type, s1_desc_share};

   ////////////////////////////////////////////////////////////////////////
   // Context decode
   wire       is_s1_s2byp = (bank_type == `BT_S1_S2BYP);
   wire       is_s2_only  = (bank_type == `BT_S2);
   wire       is_nested   = (bank_type == `BT_S1_S2);
   wire       xlat_path   = !global_bypass && !entry_bypass;
   wire       hyp_any     = s1_hyp_context_bit || s2_hyp_context_bit;

   reg  [7:0] s1_attr;
   reg  [7:0] fin;
   reg  [2:0] s2_mt;
   reg  [1:0] s2_sh;
   reg  [1:0] s2_ra_cfg;
   reg  [1:0] s2_wa_cfg;
   reg        instr_v;
   reg        priv_v;
   reg        hyp_v;
   reg        err_v;

   ////////////////////////////////////////////////////////////////////////
   // Stage 1 result
   // a stage 2 initial bank keeps the stream-transformed attributes
   always @* begin
      s1_attr = xform(stream_to_context_entry, in_attr, 1'b1);
      if (!is_s2_only) begin
         if (s1_mmu_enable_bit)
            s1_attr = s1_desc_attr;
         else
            s1_attr = xform(s1_bank_control_reg, s1_attr, 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stage 2 source selection
   always @* begin
      if (is_s1_s2byp) begin
         s2_mt     = field_mt(bank_attribute_reg);
         s2_sh     = field_sh(bank_attribute_reg);
         s2_ra_cfg = field_ra(bank_attribute_reg);
         s2_wa_cfg = field_wa(bank_attribute_reg);
      end else if (s2_mmu_enable_bit) begin
         s2_mt     = s2_desc_mem_type;
         s2_sh     = s2_desc_share;
         s2_ra_cfg = s2_desc_read_alloc_cfg;
         s2_wa_cfg = s2_desc_write_alloc_cfg;
      end else begin
         s2_mt     = field_mt(s2_bank_control_reg);
         s2_sh     = field_sh(s2_bank_control_reg);
         s2_ra_cfg = field_ra(s2_bank_control_reg);
         s2_wa_cfg = field_wa(s2_bank_control_reg);
      end
      // Keep code at stage 2 means no shareability demand
      if (s2_sh == `SHAREABILITY_CFG_KEEP)
         s2_sh = `SH_NSH;
   end

   ////////////////////////////////////////////////////////////////////////
   // Final attributes
   always @* begin
      fin = in_attr;
      if (global_bypass) begin
         fin = xform(global_control_reg, in_attr, 1'b1);
      end else if (entry_bypass) begin
         fin = xform(stream_to_context_entry, in_attr, 1'b1);
      end else begin
         fin[7]   = s1_attr[7];
         fin[6]   = alloc_apply(s2_ra_cfg, s1_attr[6]);
         fin[5]   = alloc_apply(s2_wa_cfg, s1_attr[5]);
         fin[4:2] = stronger_mt(s1_attr[4:2], s2_mt);
         fin[1:0] = stronger_sh(s1_attr[1:0], s2_sh);
      end
      if (fin[4:2] <= `MT_DEV)
         fin[1:0] = `SH_OSH;
   end

   ////////////////////////////////////////////////////////////////////////
   // Permission attributes, translated path only
   always @* begin
      instr_v = req_instr;
      priv_v  = req_priv;
      if (xlat_path) begin
         // Instruction writes are optional, so writes keep their marking by default
         if (!req_write || INSTR_ON_WRITE != 0)
            instr_v = ip_apply(instr_fetch_cfg, req_instr);
         priv_v = ip_apply(privilege_cfg, req_priv);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hypervisor marking and nesting check
   always @* begin
      hyp_v = 1'b0;
      err_v = 1'b0;
      if (xlat_path) begin
         hyp_v = stage1_support && is_s1_s2byp && s1_hyp_context_bit;
         err_v = is_nested && hyp_any;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Final attribute fields
   wire       fin_ns = fin[7];
   wire       fin_ra = fin[6];
   wire       fin_wa = fin[5];
   wire [2:0] fin_mt = fin[4:2];
   wire [1:0] fin_sh = fin[1:0];

   ////////////////////////////////////////////////////////////////////////
   // Output stage, one slot
   // A stalled slot drops req_ready, so the client holds its request
   reg valid_reg;
   assign out_valid = valid_reg;
   assign req_ready = !valid_reg || out_ready;

   always @(posedge clk_sys) begin
      if (!resetn) begin
         valid_reg    <= 1'b0;
         out_addr     <= {ADDR_W{1'b0}};
         out_write    <= 1'b0;
         out_mem_type <= `MT_SO;
         out_share    <= `SH_OSH;
         out_ra       <= 1'b0;
         out_wa       <= 1'b0;
         out_ns       <= 1'b0;
         out_instr    <= 1'b0;
         out_priv     <= 1'b0;
         out_hyp      <= 1'b0;
         cfg_error    <= 1'b0;
      end else if (req_ready) begin
         valid_reg <= req_valid;
         if (req_valid) begin
            out_addr     <= xlat_path ? xlat_addr : req_addr;
            out_write    <= req_write;
            out_mem_type <= fin_mt;
            out_share    <= fin_sh;
            out_ra       <= fin_ra;
            out_wa       <= fin_wa;
            out_ns       <= fin_ns;
            out_instr    <= instr_v;
            out_priv     <= priv_v;
            out_hyp      <= hyp_v;
            cfg_error    <= err_v;
         end
      end
   end

endmodule // memory_attribute_combiner

// ===== rtl/attr_combiner_consts.vh
// Summary of operation
// - Final Strongly-ordered or Device memory is always marked Outer Shareable.
// - Global bypass of stream mapping uses global control transformation fields.
// - Bypass-type stream entry transforms attributes from its own fields only.
// - Stage 1 with MMU off: stream entry transform, then bank control transform.
// - Stage 1 with MMU on: descriptor supplies the memory attributes.
// - Descriptor attributes override all stream fields except instruction and privilege.
// - Stage 1 with stage 2 bypass: stage 2 attributes from bank attribute register.
// - Nested: stage 2 from bank control when MMU off, tables when on.
// - Initial stage 2 bank: stage 1 skipped, stream-transformed attributes feed stage 2 as nested.
// - Stage 2 only strengthens memory type; stronger of the two wins.
// - Shareability combines by picking the stronger value.
// - Stage 2 allocate hints from bank control when MMU off, descriptor bits when on.
// - With mem_type_cfg 0, Secure transactions still get the nonsecure override.
// - With mem_type_cfg 1, bypass transformation is always applied.
// - Instruction override applies to reads; for writes a fixed parameter choice.
// - Hypervisor contexts offered only when stage1_support is 1.
// - Stage 1 bank with stage 2 bypass is hypervisor bank when its hyp_context_bit is 1.
// - Hypervisor banks are never nested.
// - Allocate cfg: 00 keep, 10 allocate, 11 no-allocate, 01 reserved.
`ifndef ATTR_COMBINER_CONSTS_VH
`define ATTR_COMBINER_CONSTS_VH
// Memory type codes, strongest has the lowest code
`define MT_SO        3'h0
`define MT_DEV       3'h1
`define MT_NC        3'h2
`define MT_WT        3'h3
`define MT_WB        3'h4
// Shareability codes, strongest has the lowest code
`define SH_OSH       2'h0
`define SH_ISH       2'h1
`define SH_NSH       2'h2
// Allocate configuration encodings
`define ALLOC_KEEP   2'h0
`define ALLOC_RSVD   2'h1
`define ALLOC_FORCE  2'h2
`define ALLOC_NONE   2'h3
// Bank formats
`define BT_S1_S2BYP  2'h0
`define BT_S2        2'h1
`define BT_S1_S2     2'h2
// Transformation field group layout: {ns_cfg[1:0],wa[1:0],ra[1:0],mem_type_cfg,mt[2:0],sh_cfg[1:0]}
`define XF_W         12
`define XF_SH_LSB    0
`define XF_MT_LSB    2
`define XF_MEM_TYPE_CFG     5
`define XF_RA_LSB    6
`define XF_WA_LSB    8
`define XF_NS_LSB    10
// Shareability cfg 2'h3 keeps the previous value
`define SHAREABILITY_CFG_KEEP   2'h3
// Nonsecure cfg: 00 keep, 10 secure, 11 nonsecure
`define NS_KEEP      2'h0
`define NS_SEC       2'h2
`define NS_NONSEC    2'h3
// Instruction and privilege cfg: 00 keep, 10 data/unpriv, 11 instr/priv
`define IP_KEEP      2'h0
`define IP_CLR       2'h2
`define IP_SET       2'h3
`endif

// ===== sim/attr_combiner_chk.sv
`timescale 1ns/1ps
module attr_combiner_chk #(
   parameter ADDR_W = 40
) (
   input wire              clk_sys,
   input wire              resetn,
   input wire              req_valid,
   input wire              req_ready,
   input wire [ADDR_W-1:0] req_addr,
   input wire              req_write,
   input wire              global_bypass,
   input wire              entry_bypass,
   input wire [1:0]        bank_type,
   input wire              s1_hyp_context_bit,
   input wire              s2_hyp_context_bit,
   input wire              stage1_support,
   input wire              s2_mmu_enable_bit,
   input wire [2:0]        s2_desc_mem_type,
   input wire [1:0]        s2_desc_share,
   input wire [1:0]        s2_desc_read_alloc_cfg,
   input wire              out_valid,
   input wire              out_ready,
   input wire [ADDR_W-1:0] out_addr,
   input wire              out_write,
   input wire [2:0]        out_mem_type,
   input wire [1:0]        out_share,
   input wire              out_ra,
   input wire              out_hyp,
   input wire              cfg_error
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire tk    = req_valid && req_ready;
   wire trans = tk && !global_bypass && !entry_bypass;
   wire hyp   = s1_hyp_context_bit || s2_hyp_context_bit;
   // Hyp bits excluded: a refused nesting may not carry stage 2 results
   wire nest2 = trans && bank_type == 2'h2 && s2_mmu_enable_bit && !hyp;
   ////////////////////////////////////////////////////////////////////////////
   property p_so_osh; out_valid && out_mem_type <= 3'h1 |-> out_share == 2'h0; endproperty
   a_so_osh: assert property (p_so_osh) else $error("strong type not outer shareable");
   property p_hold;
      out_valid && !out_ready |=> out_valid && $stable(out_addr) && $stable({out_mem_type, out_share, out_write});
   endproperty
   a_hold: assert property (p_hold) else $error("output changed while stalled");
   property p_answer; tk |=> out_valid && out_write == $past(req_write); endproperty
   a_answer: assert property (p_answer) else $error("result not one cycle after request");
   property p_byp_addr; tk && global_bypass |=> out_addr == $past(req_addr); endproperty
   a_byp_addr: assert property (p_byp_addr) else $error("bypass address altered");
   property p_s2_type; nest2 |=> out_mem_type <= $past(s2_desc_mem_type); endproperty
   a_s2_type: assert property (p_s2_type) else $error("stage 2 type weakened");
   property p_s2_share; nest2 |=> out_share <= $past(s2_desc_share); endproperty
   a_s2_share: assert property (p_s2_share) else $error("stage 2 share weakened");
   property p_s2_alloc; nest2 && s2_desc_read_alloc_cfg == 2'h2 |=> out_ra; endproperty
   a_s2_alloc: assert property (p_s2_alloc) else $error("descriptor read allocate lost");
   property p_hyp_nest; trans && bank_type == 2'h2 && hyp |=> cfg_error && !out_hyp; endproperty
   a_hyp_nest: assert property (p_hyp_nest) else $error("nested hyp bank accepted");
   property p_hyp_sup; tk && !stage1_support |=> !out_hyp; endproperty
   a_hyp_sup: assert property (p_hyp_sup) else $error("hyp without stage 1 support");
endmodule // attr_combiner_chk
bind memory_attribute_combiner attr_combiner_chk #(.ADDR_W(ADDR_W)) i_attr_combiner_chk (.*);

// ===== sim/client_master.sv
`timescale 1ns/1ps
module client_master (
   input  wire        clk_sys,
   input  wire        req_ready,
   output reg         req_valid,
   output reg  [39:0] req_addr,
   output reg         req_write,
   output reg  [2:0]  req_mem_type,
   output reg  [1:0]  req_share,
   output reg  [4:0]  req_misc
);
   initial {req_valid, req_addr, req_write, req_mem_type, req_share, req_misc} = 52'h0;
   // Misc order: read alloc, write alloc, nonsecure, instr, priv
   task issue(input [39:0] a, input w, input [2:0] mt, input [1:0] sh, input [4:0] m, output ok);
      integer n;
      begin
         @(posedge clk_sys);
         {req_valid, req_addr, req_write, req_mem_type, req_share, req_misc} <= {1'h1, a, w, mt, sh, m};
         ok = 0;
         for (n = 0; n < 50 && !ok; n = n + 1) begin
            @(negedge clk_sys);
            ok = req_ready;
            @(posedge clk_sys);
         end
         // Inverted lines so a stale request never looks like a fresh one
         {req_valid, req_addr, req_write, req_mem_type, req_share, req_misc} <= {1'h0, ~a, ~w, ~mt, ~sh, ~m};
      end
   endtask
endmodule // client_master

// ===== sim/memory_attribute_combiner_bench.sv
`timescale 1ns/1ps
module memory_attribute_combiner_bench;
   reg         clk_sys, resetn, global_bypass, entry_bypass, s1_hyp_context_bit, s2_hyp_context_bit;
   reg         stage1_support, s1_mmu_enable_bit, s2_mmu_enable_bit, out_ready, s1_desc_ra, s1_desc_wa, s1_desc_ns;
   reg  [1:0]  bank_type, instr_fetch_cfg, privilege_cfg, s1_desc_share, s2_desc_share;
   reg  [1:0]  s2_desc_read_alloc_cfg, s2_desc_write_alloc_cfg;
   reg  [11:0] global_control_reg, stream_to_context_entry, s1_bank_control_reg, s2_bank_control_reg;
   reg  [11:0] bank_attribute_reg;
   reg  [39:0] xlat_addr;
   reg  [2:0]  s1_desc_mem_type, s2_desc_mem_type;
   wire        req_valid, req_write, req_ra, req_wa, req_ns, req_instr, req_priv, req_ready, out_valid;
   wire        out_write, out_ra, out_wa, out_ns, out_instr, out_priv, out_hyp, cfg_error;
   wire [39:0] req_addr, out_addr;
   wire [2:0]  req_mem_type, out_mem_type;
   wire [1:0]  req_share, out_share;
   wire [4:0]  req_misc;
   integer     error_cnt, tests_run;
   assign {req_ra, req_wa, req_ns, req_instr, req_priv} = req_misc;
   memory_attribute_combiner i_memory_attribute_combiner (.*);
   client_master i_client_master (.*);
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////
   function [11:0] xf(input [1:0] ns, input [1:0] wa, input [1:0] ra, input mc, input [2:0] mt, input [1:0] sh);
      xf = {ns, wa, ra, mc, mt, sh};
   endfunction
   task chk(input [63:0] got, input [63:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("Mismatches %0d of %0d checks", error_cnt, tests_run);
         if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // Result is registered on the taking edge and checked at the next negedge
   task go(input w, input [2:0] mt, input [1:0] sh, input [4:0] m);
      reg ok;
      begin
         i_client_master.issue(40'h12_3456_7890, w, mt, sh, m, ok);
         if (!ok) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t request never taken", $time);
            complete_run;
         end
         @(negedge clk_sys);
         chk({out_valid, out_write}, {1'h1, w});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_bypass;
      begin
         @(posedge clk_sys);
         {global_bypass, entry_bypass} <= 2'h2;
         global_control_reg <= xf(0, 0, 0, 1, 3'h1, 2'h2);
         go(0, 3'h4, 2'h2, 5'h0);
         chk({out_addr, out_mem_type, out_share}, {40'h12_3456_7890, 3'h1, 2'h0});
         @(posedge clk_sys);
         {global_bypass, entry_bypass} <= 2'h1;
         stream_to_context_entry <= xf(0, 2, 3, 1, 3'h4, 2'h1);
         go(0, 3'h0, 2'h2, 5'h10);
         chk({out_mem_type, out_share, out_ra, out_wa}, {3'h4, 2'h1, 2'h1});
         @(posedge clk_sys);
         stream_to_context_entry <= xf(3, 0, 0, 0, 3'h4, 2'h3);
         go(0, 3'h0, 2'h2, 5'h0);
         chk({out_mem_type, out_share, out_ns}, {3'h0, 2'h0, 1'h1});
      end
   endtask
   task t_stage1;
      integer w;
      begin
         @(posedge clk_sys);
         {entry_bypass, bank_type, s1_mmu_enable_bit, instr_fetch_cfg, privilege_cfg} <= {1'h0, 2'h0, 1'h1, 2'h3, 2'h3};
         stream_to_context_entry <= xf(0, 0, 0, 1, 3'h0, 2'h2);
         {s1_desc_mem_type, s1_desc_share, xlat_addr} <= {3'h4, 2'h1, 40'h0a_bcde_f000};
         bank_attribute_reg <= xf(0, 0, 0, 1, 3'h2, 2'h2);
         for (w = 0; w < 2; w = w + 1) begin
            go(w, 3'h3, 2'h2, 5'h0);
            chk({out_addr, out_mem_type, out_share, out_instr}, {40'h0a_bcde_f000, 3'h2, 2'h1, w == 0});
            chk(out_priv, 1'h1);
         end
      end
   endtask
   task t_nested;
      begin
         @(posedge clk_sys);
         {bank_type, s1_mmu_enable_bit, s2_mmu_enable_bit} <= {2'h2, 1'h0, 1'h1};
         stream_to_context_entry <= xf(0, 0, 0, 1, 3'h4, 2'h2);
         s1_bank_control_reg <= xf(0, 0, 0, 1, 3'h3, 2'h1);
         s2_bank_control_reg <= xf(0, 3, 2, 1, 3'h1, 2'h2);
         {s2_desc_mem_type, s2_desc_share, s2_desc_read_alloc_cfg, s2_desc_write_alloc_cfg} <= {3'h4, 2'h2, 2'h2, 2'h3};
         go(0, 3'h4, 2'h2, 5'h08);
         chk({out_mem_type, out_share, out_ra, out_wa}, {3'h3, 2'h1, 2'h2});
         @(posedge clk_sys);
         s2_mmu_enable_bit <= 1'h0;
         go(0, 3'h4, 2'h2, 5'h08);
         chk({out_mem_type, out_share, out_ra, out_wa}, {3'h1, 2'h0, 2'h2});
         @(posedge clk_sys);
         {bank_type, s2_mmu_enable_bit} <= {2'h1, 1'h1};
         stream_to_context_entry <= xf(0, 0, 0, 1, 3'h2, 2'h1);
         go(0, 3'h4, 2'h2, 5'h0);
         chk({out_mem_type, out_share}, {3'h2, 2'h1});
      end
   endtask
   task t_hyp;
      begin
         @(posedge clk_sys);
         {bank_type, s1_hyp_context_bit, stage1_support} <= {2'h2, 1'h1, 1'h1};
         go(0, 3'h4, 2'h2, 5'h0);
         chk(cfg_error, 1'h1);
         @(posedge clk_sys);
         bank_type <= 2'h0;
         go(0, 3'h4, 2'h2, 5'h0);
         chk({cfg_error, out_hyp}, 2'h1);
         @(posedge clk_sys);
         stage1_support <= 1'h0;
         go(0, 3'h4, 2'h2, 5'h0);
         chk(out_hyp, 1'h0);
      end
   endtask
   task t_stall;
      begin
         @(posedge clk_sys);
         out_ready <= 1'h0;
         go(1, 3'h4, 2'h2, 5'h0);
         repeat (3) @(negedge clk_sys);
         chk({out_valid, req_ready, out_write}, 3'h5);
         @(posedge clk_sys);
         out_ready <= 1'h1;
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk(out_valid, 1'h0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {global_bypass, entry_bypass, s1_hyp_context_bit, s2_hyp_context_bit, stage1_support} = 5'h0;
      {s1_mmu_enable_bit, s2_mmu_enable_bit, s1_desc_ra, s1_desc_wa, s1_desc_ns, bank_type} = 7'h0;
      {instr_fetch_cfg, privilege_cfg, s1_desc_share, s2_desc_share} = 8'h0;
      {s2_desc_read_alloc_cfg, s2_desc_write_alloc_cfg, s1_desc_mem_type, s2_desc_mem_type} = 10'h0;
      {global_control_reg, stream_to_context_entry, s1_bank_control_reg} = 36'h0;
      {s2_bank_control_reg, bank_attribute_reg, xlat_addr} = 64'h0;
      resetn = 1'b0;
      out_ready = 1'b1;
      error_cnt = 0;
      tests_run = 0;
      repeat (20) @(posedge clk_sys);
      chk({out_valid, req_ready}, 2'h1);
      resetn <= 1'h1;
      t_bypass;
      t_stage1;
      t_nested;
      t_hyp;
      t_stall;
      complete_run;
   end
endmodule // memory_attribute_combiner_bench
